/* File: pipelined_sync_burst_sram.sv */
// Pipelined synchronous burst memory of 64K words by 32 bits with a common data bus.
`default_nettype none
module pipelined_sync_burst_sram (
	input wire logic clk,
	input wire logic rst,
	input wire logic [sram_pkg::ADDR_WIDTH-1:0] address,
	input wire logic [sram_pkg::DATA_WIDTH-1:0] dataIn,
	output logic [sram_pkg::DATA_WIDTH-1:0] dataOut,
	output logic dataOutEnable,
	input wire logic proc_addr_strobe_n,
	input wire logic ctrl_addr_strobe_n,
	input wire logic burst_advance_n,
	input wire logic all_bytes_write_n,
	input wire logic lane_write_enable_n,
	input wire logic [sram_pkg::LANES-1:0] lane_select_n,
	input wire logic select_low_first_n,
	input wire logic select_high_second,
	input wire logic select_low_third_n,
	input wire logic outputEnable_n,
	input wire logic sleep_request,
	input wire logic burstOrderSelect
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [sram_pkg::ADDR_WIDTH-1:0] addressReg;
	logic [sram_pkg::DATA_WIDTH-1:0] dataReg;
	logic procStrobeReg_n;
	logic ctrlStrobeReg_n;
	logic advanceReg_n;
	logic allBytesReg_n;
	logic laneEnableReg_n;
	logic [sram_pkg::LANES-1:0] laneSelectReg_n;
	logic firstEnableReg_n;
	logic secondEnableReg;
	logic thirdEnableReg_n;
	logic interleavedOrder;
	logic selectedReg;
	logic [sram_pkg::HIGH_WIDTH-1:0] highAddrReg;
	sram_pkg::access_state_t accessState;
	sram_pkg::access_state_t next_accessState;
	logic procStart;
	logic ctrlStart;
	logic strobeLoad;
	logic enablesActive;
	logic addressLoad;
	logic selectedNow;
	logic accessActive;
	logic burstStep;
	logic allBytesWrite;
	logic laneWrite;
	logic [sram_pkg::LANES-1:0] laneMask;
	logic doWrite;
	logic doRead;
	logic [sram_pkg::HIGH_WIDTH-1:0] highAddr;
	logic [sram_pkg::COUNT_WIDTH-1:0] lowBits;
	logic [sram_pkg::ADDR_WIDTH-1:0] accessAddr;

	// ------------------------------------------------------------------
	// Input registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			addressReg <= sram_pkg::ADDR_RESET;
		end else begin
			addressReg <= address;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			dataReg <= sram_pkg::DATA_RESET;
		end else begin
			dataReg <= dataIn;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			procStrobeReg_n <= sram_pkg::STROBE_IDLE;
			ctrlStrobeReg_n <= sram_pkg::STROBE_IDLE;
		end else begin
			procStrobeReg_n <= proc_addr_strobe_n;
			ctrlStrobeReg_n <= ctrl_addr_strobe_n;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			advanceReg_n <= sram_pkg::STROBE_IDLE;
		end else begin
			advanceReg_n <= burst_advance_n;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			allBytesReg_n <= sram_pkg::STROBE_IDLE;
			laneEnableReg_n <= sram_pkg::STROBE_IDLE;
		end else begin
			allBytesReg_n <= all_bytes_write_n;
			laneEnableReg_n <= lane_write_enable_n;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			laneSelectReg_n <= sram_pkg::LANES_IDLE;
		end else begin
			laneSelectReg_n <= lane_select_n;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			firstEnableReg_n <= sram_pkg::ENABLE_LOW_IDLE;
			secondEnableReg <= sram_pkg::ENABLE_HIGH_IDLE;
			thirdEnableReg_n <= sram_pkg::ENABLE_LOW_IDLE;
		end else begin
			firstEnableReg_n <= select_low_first_n;
			secondEnableReg <= select_high_second;
			thirdEnableReg_n <= select_low_third_n;
		end
	end

	// ------------------------------------------------------------------
	// Burst order strap
	// ------------------------------------------------------------------
	// The order is caught while reset is held and then kept, so a change
	// on the pin during operation cannot corrupt a running burst.
	always_ff @(posedge clk) begin
		if (rst) begin
			interleavedOrder <= burstOrderSelect;
		end
	end

	// ------------------------------------------------------------------
	// Strobe decode
	// ------------------------------------------------------------------
	always_comb begin
		procStart = ~procStrobeReg_n & ~firstEnableReg_n;
		ctrlStart = ~ctrlStrobeReg_n & procStrobeReg_n;
		strobeLoad = procStart | ctrlStart;
		enablesActive = ~firstEnableReg_n & secondEnableReg & ~thirdEnableReg_n;
		addressLoad = strobeLoad & enablesActive;
	end

	// ------------------------------------------------------------------
	// Selection state
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			selectedReg <= 1'h0;
		end else if (strobeLoad) begin
			selectedReg <= enablesActive;
		end
	end

	always_comb begin
		selectedNow = strobeLoad ? enablesActive : selectedReg;
		accessActive = selectedNow & ~sleep_request;
		burstStep = ~advanceReg_n & ~strobeLoad & selectedReg;
	end

	// ------------------------------------------------------------------
	// Address generation
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			highAddrReg <= sram_pkg::HIGH_RESET;
		end else if (addressLoad) begin
			highAddrReg <= addressReg[sram_pkg::ADDR_WIDTH-1:sram_pkg::COUNT_WIDTH];
		end
	end

	always_comb begin
		if (addressLoad) begin
			highAddr = addressReg[sram_pkg::ADDR_WIDTH-1:sram_pkg::COUNT_WIDTH];
		end else begin
			highAddr = highAddrReg;
		end
		accessAddr = {highAddr, lowBits};
	end

	burst_counter counter (
		.clk(clk),
		.rst(rst),
		.load(addressLoad),
		.advance(burstStep),
		.interleaved(interleavedOrder),
		.startBits(addressReg[sram_pkg::COUNT_WIDTH-1:0]),
		.lowBits(lowBits)
	);

	// ------------------------------------------------------------------
	// Write lane decode
	// ------------------------------------------------------------------
	always_comb begin
		allBytesWrite = ~allBytesReg_n;
		laneWrite = ~laneEnableReg_n & allBytesReg_n;
	end

	for (genvar lane = 0; lane < sram_pkg::LANES; lane++) begin : gMask
		always_comb begin
			laneMask[lane] = allBytesWrite | (laneWrite & ~laneSelectReg_n[lane]);
		end
	end

	always_comb begin
		doWrite = accessActive & (|laneMask);
		doRead = accessActive & ~(|laneMask);
	end

	// ------------------------------------------------------------------
	// Word array and output register
	// ------------------------------------------------------------------
	sram_array array (
		.clk(clk),
		.rst(rst),
		.writeEnable(doWrite),
		.readEnable(doRead),
		.laneMask(laneMask),
		.address(accessAddr),
		.writeData(dataReg),
		.readData(dataOut)
	);

	// ------------------------------------------------------------------
	// Access state on the output side
	// ------------------------------------------------------------------
	always_comb begin
		case (1'b1)
			doWrite: begin
				next_accessState = sram_pkg::ACC_WRITE;
			end
			doRead: begin
				next_accessState = sram_pkg::ACC_READ;
			end
			default: begin
				next_accessState = sram_pkg::ACC_DESELECTED;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			accessState <= sram_pkg::ACC_DESELECTED;
		end else begin
			accessState <= next_accessState;
		end
	end

	// ------------------------------------------------------------------
	// Data bus drive
	// ------------------------------------------------------------------
	// The bus is driven only while the output register holds a read result,
	// so the clock in which a read emerges from deselect never drives it.
	always_comb begin
		case (accessState)
			sram_pkg::ACC_READ: begin
				dataOutEnable = ~outputEnable_n & ~sleep_request;
			end
			sram_pkg::ACC_WRITE: begin
				dataOutEnable = 1'h0;
			end
			default: begin
				dataOutEnable = 1'h0;
			end
		endcase
	end

endmodule // pipelined_sync_burst_sram
`default_nettype wire

/* File: sram_pkg.sv */
// Shared widths, reset values and access states of the pipelined burst memory.
`default_nettype none
package sram_pkg;

	// ------------------------------------------------------------------
	// Widths and sizes
	// ------------------------------------------------------------------
	localparam int ADDR_WIDTH = 16;
	localparam int DATA_WIDTH = 32;
	localparam int LANES = 4;
	localparam int LANE_WIDTH = 8;
	localparam int COUNT_WIDTH = 2;
	localparam int HIGH_WIDTH = ADDR_WIDTH - COUNT_WIDTH;
	localparam int WORDS = 65536;

	// ------------------------------------------------------------------
	// Values after reset, burst count step and interleaved mode code
	// ------------------------------------------------------------------
	localparam logic STROBE_IDLE = 1'h1;
	localparam logic ENABLE_LOW_IDLE = 1'h1;
	localparam logic ENABLE_HIGH_IDLE = 1'h0;
	localparam logic [LANES-1:0] LANES_IDLE = 4'hf;
	localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 2'h0;
	localparam logic [COUNT_WIDTH-1:0] COUNT_STEP = 2'h1;
	localparam logic [ADDR_WIDTH-1:0] ADDR_RESET = 16'h0000;
	localparam logic [HIGH_WIDTH-1:0] HIGH_RESET = 14'h0000;
	localparam logic [DATA_WIDTH-1:0] DATA_RESET = 32'h00000000;
	localparam logic MODE_INTERLEAVED = 1'h1;

	// ------------------------------------------------------------------
	// Cycle counts of a four-word burst
	// ------------------------------------------------------------------
	localparam int FIRST_WORD_CLOCKS = 3;
	localparam int NEXT_WORD_CLOCKS = 1;

	// ------------------------------------------------------------------
	// State of the access whose result is on the output side
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ACC_DESELECTED = 3'h1,
		ACC_READ = 3'h2,
		ACC_WRITE = 3'h4
	} access_state_t;

endpackage
`default_nettype wire

/* File: burst_counter.sv */
// Two-bit wrap-around burst counter with linear and interleaved order.
`default_nettype none
module burst_counter (
	input wire logic clk,
	input wire logic rst,
	input wire logic load,
	input wire logic advance,
	input wire logic interleaved,
	input wire logic [sram_pkg::COUNT_WIDTH-1:0] startBits,
	output logic [sram_pkg::COUNT_WIDTH-1:0] lowBits
);

	logic [sram_pkg::COUNT_WIDTH-1:0] startReg;
	logic [sram_pkg::COUNT_WIDTH-1:0] countReg;
	logic [sram_pkg::COUNT_WIDTH-1:0] next_start;
	logic [sram_pkg::COUNT_WIDTH-1:0] next_count;

	// ------------------------------------------------------------------
	// Word offset used by the access of this cycle
	// ------------------------------------------------------------------
	always_comb begin
		next_start = load ? startBits : startReg;
		if (load) begin
			next_count = sram_pkg::COUNT_RESET;
		end else if (advance) begin
			next_count = countReg + sram_pkg::COUNT_STEP;
		end else begin
			next_count = countReg;
		end
		if (interleaved) begin
			lowBits = next_start ^ next_count;
		end else begin
			lowBits = next_start + next_count;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			startReg <= sram_pkg::COUNT_RESET;
			countReg <= sram_pkg::COUNT_RESET;
		end else begin
			startReg <= next_start;
			countReg <= next_count;
		end
	end

endmodule // burst_counter
`default_nettype wire

/* File: sram_array.sv */
// Word array with per-lane write and a registered read port.
`default_nettype none
module sram_array (
	input wire logic clk,
	input wire logic rst,
	input wire logic writeEnable,
	input wire logic readEnable,
	input wire logic [sram_pkg::LANES-1:0] laneMask,
	input wire logic [sram_pkg::ADDR_WIDTH-1:0] address,
	input wire logic [sram_pkg::DATA_WIDTH-1:0] writeData,
	output logic [sram_pkg::DATA_WIDTH-1:0] readData
);

	logic [sram_pkg::DATA_WIDTH-1:0] cells [0:sram_pkg::WORDS-1];

	// ------------------------------------------------------------------
	// Lane writes, completed at the edge that ends the access cycle
	// ------------------------------------------------------------------
	for (genvar lane = 0; lane < sram_pkg::LANES; lane++) begin : gLane
		always_ff @(posedge clk) begin
			if (writeEnable && laneMask[lane]) begin
				cells[address][lane*sram_pkg::LANE_WIDTH +: sram_pkg::LANE_WIDTH] <=
					writeData[lane*sram_pkg::LANE_WIDTH +: sram_pkg::LANE_WIDTH];
			end
		end
	end

	// ------------------------------------------------------------------
	// Output register
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			readData <= sram_pkg::DATA_RESET;
		end else if (readEnable) begin
			readData <= cells[address];
		end
	end

endmodule // sram_array
`default_nettype wire

/* File: bus_partner.sv */
// Shared data bus between the memory and the bus master.
`default_nettype none
module bus_partner (
	input wire logic clk,
	input wire logic [31:0] devData,
	input wire logic devDrive,
	input wire logic [31:0] hostData,
	input wire logic hostDrive,
	output logic [31:0] level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] last = 32'h0;
	// An undriven bus shows a changing pattern, never the last value.
	always_comb begin
		if (hostDrive) begin
			level = hostData;
		end else if (devDrive) begin
			level = devData;
		end else begin
			level = ~last;
		end
	end
	always @(posedge clk) begin
		last <= level;
	end
endmodule // bus_partner
`default_nettype wire

/* File: sram_chk.sv */
// Concurrent checks on the ports of the burst memory.
`default_nettype none
module sram_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic [15:0] address,
	input wire logic [31:0] dataIn,
	input wire logic [31:0] dataOut,
	input wire logic dataOutEnable,
	input wire logic proc_addr_strobe_n,
	input wire logic ctrl_addr_strobe_n,
	input wire logic burst_advance_n,
	input wire logic all_bytes_write_n,
	input wire logic lane_write_enable_n,
	input wire logic [3:0] lane_select_n,
	input wire logic select_low_first_n,
	input wire logic select_high_second,
	input wire logic select_low_third_n,
	input wire logic outputEnable_n,
	input wire logic sleep_request,
	input wire logic burstOrderSelect
);
	wire logic sel = !select_low_first_n && select_high_second && !select_low_third_n;
	wire logic procLd = !proc_addr_strobe_n && !select_low_first_n;
	wire logic ld = procLd || (!ctrl_addr_strobe_n && proc_addr_strobe_n);
	wire logic wrc = !all_bytes_write_n || (!lane_write_enable_n && !(&lane_select_n));
	wire logic shown = dataOutEnable || outputEnable_n || sleep_request;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence rdLoad;
		ld && sel && !wrc && !sleep_request;
	endsequence
	sequence wrLoad;
		ld && sel && wrc;
	endsequence
	sequence deLoad;
		ld && !sel;
	endsequence
	sequence burstStep;
		!ld && !burst_advance_n && !sleep_request && !wrc;
	endsequence
	read_drive_a: assert property (rdLoad ##1 !sleep_request |-> ##1 shown)
		else $error("read result not driven");
	burst_run_a: assert property (rdLoad ##1 burstStep [*3] |-> shown [*3])
		else $error("burst words not driven");
	write_quiet_a: assert property (wrLoad |-> ##2 !dataOutEnable)
		else $error("bus driven after write");
	write_hold_a: assert property (wrLoad |-> ##2 $stable(dataOut))
		else $error("read data changed by write");
	deselect_quiet_a: assert property (deLoad |-> ##2 !dataOutEnable)
		else $error("bus driven while deselected");
	proc_ignored_a: assert property (deLoad ##1 (!proc_addr_strobe_n && select_low_first_n)
		|-> ##2 !dataOutEnable)
		else $error("ignored strobe selected the memory");
	oe_float_a: assert property (outputEnable_n |-> !dataOutEnable)
		else $error("bus driven with output enable high");
	sleep_float_a: assert property (sleep_request |-> !dataOutEnable)
		else $error("bus driven during sleep");
	reset_clear_a: assert property (disable iff (1'b0) rst |=> dataOut == 32'h0 && !dataOutEnable)
		else $error("outputs not cleared by reset");
endmodule // sram_chk
bind pipelined_sync_burst_sram sram_chk sram_chk_inst (.clk, .rst, .address, .dataIn,
	.dataOut, .dataOutEnable, .proc_addr_strobe_n, .ctrl_addr_strobe_n, .burst_advance_n,
	.all_bytes_write_n, .lane_write_enable_n, .lane_select_n, .select_low_first_n,
	.select_high_second, .select_low_third_n, .outputEnable_n, .sleep_request,
	.burstOrderSelect);
`default_nettype wire

/* File: pipelined_sync_burst_sram_tb.sv */
// Self-checking bench of the pipelined burst memory.
`default_nettype none
module pipelined_sync_burst_sram_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [2:0] DES = 3'h4, CONT = 3'h6, CLD = 3'h5, PLD = 3'h3;
	localparam logic [6:0] IDLE = 7'h7f;
	logic clk = 0, rst = 1, pStbN = 1, cStbN = 1, stepN = 1, allWrN = 1, laneEnN = 1;
	logic firstN = 0, second = 0, thirdN = 0, oeN = 0, sleep = 0, order = 0, hostDrive = 0;
	logic dataOutEnable;
	logic [3:0] laneSelN = 4'hf;
	logic [15:0] addr = 16'h0000;
	logic [31:0] hostData = 32'h0, seed = 32'hc56a, bus, dataOut;
	logic [31:0] mem [int];
	logic [31:0] expq [$];
	int bad_count = 0, compares = 0, cycles = 0;
	pipelined_sync_burst_sram pipelined_sync_burst_sram_inst (.clk(clk), .rst(rst),
		.address(addr), .dataIn(bus), .dataOut(dataOut), .dataOutEnable(dataOutEnable),
		.proc_addr_strobe_n(pStbN), .ctrl_addr_strobe_n(cStbN), .burst_advance_n(stepN),
		.all_bytes_write_n(allWrN), .lane_write_enable_n(laneEnN), .lane_select_n(laneSelN),
		.select_low_first_n(firstN), .select_high_second(second), .select_low_third_n(thirdN),
		.outputEnable_n(oeN), .sleep_request(sleep), .burstOrderSelect(order));
	bus_partner bus_partner_inst (.clk(clk), .devData(dataOut), .devDrive(dataOutEnable),
		.hostData(hostData), .hostDrive(hostDrive), .level(bus));
	initial forever #2.5 clk = ~clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic miss(input string m);
		bad_count++;
		$display("unexpected at %0t: %s", $time, m);
	endtask
	task automatic end_sim();
		$display("%0d mismatches in %0d compares", bad_count, compares);
		if (bad_count == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic note(input logic [31:0] d);
		if (!oeN && !sleep) expq.push_back(d);
	endtask
	// One cycle of strobes, second enable and write controls, both strobes set from k.
	task automatic tick(input logic [2:0] k, input logic [6:0] c);
		@(negedge clk);
		{pStbN, cStbN, second} <= k;
		{stepN, allWrN, laneEnN, laneSelN} <= c;
		hostDrive <= !c[5] || (!c[4] && !(&c[3:0]));
	endtask
	task automatic wr(input logic [15:0] a, input logic [6:0] c);
		logic [31:0] d;
		d = rnd();
		tick(CLD, c);
		addr <= a;
		hostData <= d;
		if (c[5] && (c[4] || &c[3:0])) note(mem[a]);
		else if (!sleep) for (int i = 0; i < 4; i++) if (!c[5] || !c[i])
			mem[a][8*i+:8] = d[8*i+:8];
	endtask
	task automatic rd(input logic [15:0] a, input int h);
		logic [15:0] p, b;
		p = a;
		tick(PLD, IDLE);
		addr <= a;
		note(mem[a]);
		for (int i = 1; i < 4; i++) begin
			if (i == h) begin
				tick(CONT, IDLE);
				note(mem[p]);
			end
			b = {a[15:2], order ? a[1:0] ^ i[1:0] : a[1:0] + i[1:0]};
			tick(CONT, 7'h3f);
			note(mem[b]);
			p = b;
		end
	endtask
	always @(posedge clk) begin
		#1;
		if (dataOutEnable === 1'b1) begin
			compares++;
			if (expq.size() == 0) miss("drive with no read pending");
			else if (dataOut !== expq.pop_front()) miss("read data differs");
		end
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			miss("timeout");
			end_sim();
		end
	end
	initial begin
		logic [31:0] v;
		repeat (4) @(negedge clk);
		rst <= 0;
		for (int i = 0; i < 16; i++) begin
			v = rnd();
			if (i < 8) wr(16'h1230 + 16'(i), {2'h2, v[4:0]});
			else wr(16'h1230 + {13'h0, v[7:5]}, {3'h6, v[3:0]});
		end
		wr(16'h1231, 7'h70);
		for (int j = 0; j < 8; j++) rd(16'h1230 + 16'(j), j & 3);
		tick(DES, IDLE);
		firstN = 1;
		tick(3'h1, 7'h4f);
		addr <= 16'h1230;
		hostData <= rnd();
		tick(DES, IDLE);
		firstN = 0;
		rd(16'h1230, 0);
		repeat (3) tick(DES, IDLE);
		sleep = 1;
		wr(16'h1232, 7'h40);
		rd(16'h1232, 0);
		repeat (3) tick(DES, IDLE);
		sleep = 0;
		rd(16'h1232, 0);
		repeat (3) tick(DES, IDLE);
		oeN = 1;
		rd(16'h1233, 2);
		repeat (3) tick(DES, IDLE);
		oeN = 0;
		rst <= 1;
		order <= 1;
		repeat (4) @(negedge clk);
		rst <= 0;
		for (int j = 0; j < 8; j++) rd(16'h1237 - 16'(j), j & 3);
		wr(16'h1235, 7'h40);
		rd(16'h1235, 0);
		repeat (4) tick(DES, IDLE);
		if (expq.size() != 0) miss("reads never driven");
		end_sim();
	end
endmodule // pipelined_sync_burst_sram_tb
`default_nettype wire
